// ### hdl/uef_pkg.sv
// Constants and carrier types for the circular endpoint FIFO pointer block
package uef_pkg;
    // Widths
    localparam int PTR_W = 16;
    localparam int ADDR_W = 18;
    localparam int DATA_W = 16;
    localparam int NAKC_W = 5;
    // Register byte offsets
    localparam logic [7:0] OFF_BASE = 8'h00;
    localparam logic [7:0] OFF_SIZE = 8'h04;
    localparam logic [7:0] OFF_RDOFF = 8'h08;
    localparam logic [7:0] OFF_WROFF = 8'h0c;
    localparam logic [7:0] OFF_POLICY = 8'h10;
    localparam logic [7:0] OFF_STATUS = 8'h14;
    // Policy field positions
    localparam int POL_LIMIT_LSB = 0;
    localparam int POL_NAKEN_BIT = 4;
    localparam int POL_DIRIN_BIT = 5;
    localparam int POL_MAXPKT_LSB = 8;
    localparam int MAXPKT_W = 10;
    // Status field positions
    localparam int ST_NAKC_LSB = 0;
    localparam int ST_EMPTY_BIT = 8;
    localparam int ST_FULL_BIT = 9;
    localparam int ST_BUSY_BIT = 10;
    localparam int ST_AVAIL_LSB = 16;
    // Reset values and the NAK count ceiling
    localparam logic [PTR_W-1:0] PTR_RST = 16'h0000;
    localparam logic [ADDR_W-1:0] BASE_RST = 18'h00000;
    localparam logic [PTR_W-1:0] SIZE_RST = 16'h0000;
    localparam logic [MAXPKT_W-1:0] MAXPKT_RST = 10'h040;
    localparam logic [NAKC_W-1:0] NAKC_MAX = 5'h1f;
    // Policy settings
    typedef struct packed {
        logic [MAXPKT_W-1:0] maxpkt_bytes;
        logic dir_in;
        logic nak_tally_enable;
        logic [3:0] short_packet_nak_limit;
    } uef_policy_t;
    // Request to the buffer memory
    typedef struct packed {
        logic req;
        logic we;
        logic [ADDR_W-1:0] addr;
        logic [DATA_W-1:0] wdata;
    } uef_mem_req_t;
endpackage : uef_pkg

// ### hdl/uef_ring.sv
// Modulo pointer arithmetic for one circular buffer
`timescale 1ns/10ps
module uef_ring (
    // Buffer geometry and pointers
    input wire logic [uef_pkg::PTR_W-1:0] size_i,
    input wire logic [uef_pkg::PTR_W-1:0] head_i,
    input wire logic [uef_pkg::PTR_W-1:0] tail_i,
    // Results
    output logic [uef_pkg::PTR_W-1:0] head_next_o,
    output logic [uef_pkg::PTR_W-1:0] dist_o
);
    import uef_pkg::*;
    logic [PTR_W:0] inc;

    // Pre-increment with wrap to zero past the last location
    always_comb begin
        inc = {1'b0, head_i} + 17'h00001;
        head_next_o = (inc >= {1'b0, size_i}) ? PTR_RST : inc[PTR_W-1:0];
        // Distance modulo size; 16-bit wrap keeps it exact as result < size
        dist_o = (head_i >= tail_i) ? head_i - tail_i : head_i - tail_i + size_i;
    end
endmodule : uef_ring

// ### hdl/uef_core.sv
// Endpoint circular FIFO pointer manager with AHB-Lite register slave
// Overview of operation
// - OUT: core owns write pointer, firmware read; IN: the reverse.
// - Read and write pointers start at zero.
// - Core wraps a pointer to zero after the buffer's last location.
// - Each pointer holds the last location acted on.
// - Pointers are incremented before use; firmware follows the same model.
// - Read pointer equal to write pointer means empty.
// - Full is write one behind read; write never advances onto read.
// - Register accesses stall buffer memory transfers while they last.
// - OUT packet stored without collision gets ACK, then write offset updates.
// - Collision during OUT gives NAK; stored write offset stays unchanged.
// - Oversize OUT packets are accepted if they fit.
// - Overflow stores until collision, drops rest, NAKs, restores write pointer.
// - IN sends full packet if available; read offset advances only on ACK.
// - Policy holds a 4-bit short packet NAK limit.
// - Each IN NAK bumps the count; above the limit a short packet goes. Core count saturates at 31.
// - NAK count clears when a data stage completes.
// - With tally disabled, IN NAKs until a full packet is available.
// - Base is 18 bits; size and offsets are 16 bits.
// - Memory is accessed in 16-bit words; packet bytes halve to words.
//
// Added by the designer: the AHB-Lite register port and the address map.
`timescale 1ns/10ps
module uef_core (
    // Clock and reset
    input wire logic clock_i,
    input wire logic rst_i,
    // AHB-Lite slave
    input wire logic hsel_i,
    input wire logic [31:0] haddr_i,
    input wire logic [1:0] htrans_i,
    input wire logic hwrite_i,
    input wire logic [2:0] hsize_i,
    input wire logic [31:0] hwdata_i,
    input wire logic hready_i,
    output logic hreadyout_o,
    output logic hresp_o,
    output logic [31:0] hrdata_o,
    // OUT packet stream from the USB engine
    input wire logic out_start_i,
    input wire logic out_valid_i,
    input wire logic [uef_pkg::DATA_W-1:0] out_word_i,
    output logic out_ready_o,
    input wire logic out_end_i,
    output logic out_hs_o,
    output logic out_ack_o,
    // IN token handling toward the USB engine
    input wire logic in_token_i,
    output logic in_send_o,
    output logic in_nak_o,
    output logic [uef_pkg::PTR_W-1:0] in_len_o,
    output logic in_word_valid_o,
    output logic [uef_pkg::DATA_W-1:0] in_word_o,
    input wire logic in_ack_i,
    input wire logic in_abort_i,
    // Buffer memory port, read data one cycle after the request
    output uef_pkg::uef_mem_req_t mem_o,
    input wire logic [uef_pkg::DATA_W-1:0] mem_rdata_i
);
    import uef_pkg::*;
    typedef enum logic [2:0] {S_IDLE, S_OUT, S_FETCH, S_WAIT, S_LATCH, S_HS} uef_state_t;
    uef_state_t state_r, state_nxt;
    logic [PTR_W-1:0] wr_r, wr_nxt, rd_r, rd_nxt, tmp_r, tmp_nxt, size_r, size_nxt;
    logic [PTR_W-1:0] remain_r, remain_nxt, len_r, len_nxt;
    logic [ADDR_W-1:0] base_r, base_nxt;
    uef_policy_t pol_r, pol_nxt;
    logic [NAKC_W-1:0] nakc_r, nakc_nxt;
    logic blocked_r, blocked_nxt, hs_r, hs_nxt, ack_r, ack_nxt;
    logic send_r, send_nxt, nak_r, nak_nxt, wv_r, wv_nxt;
    logic [DATA_W-1:0] word_r, word_nxt;
    uef_mem_req_t mem_r, mem_nxt;
    logic dph_r, dph_nxt, dwr_r, dwr_nxt;
    logic [7:0] dadr_r, dadr_nxt;
    logic [31:0] hrdata_r, hrdata_nxt;
    logic aph, io_stall, accept;
    logic [PTR_W-1:0] wr_head, rd_head, wr_adv, rd_adv, avail, maxw;
    // Register match on a word-aligned byte offset
    function automatic logic hit(input logic [7:0] a, input logic [7:0] off);
        return a[7:2] == off[7:2];
    endfunction : hit
    // Register read value for one offset; unmapped offsets read zero
    function automatic logic [31:0] rd_val(input logic [7:0] a, input logic [31:0] st,
                                           input logic [31:0] pw, input logic [ADDR_W-1:0] b,
                                           input logic [PTR_W-1:0] sz, input logic [PTR_W-1:0] r,
                                           input logic [PTR_W-1:0] w);
        rd_val = 32'h00000000;
        if (hit(a, OFF_BASE)) rd_val = {14'h0000, b};
        if (hit(a, OFF_SIZE)) rd_val = {16'h0000, sz};
        if (hit(a, OFF_RDOFF)) rd_val = {16'h0000, r};
        if (hit(a, OFF_WROFF)) rd_val = {16'h0000, w};
        if (hit(a, OFF_POLICY)) rd_val = pw;
        if (hit(a, OFF_STATUS)) rd_val = st;
    endfunction : rd_val
    // Working pointer replaces the committed one only while a packet runs
    assign wr_head = (state_r == S_OUT) ? tmp_r : wr_r;
    assign rd_head = (state_r inside {S_FETCH, S_WAIT, S_LATCH, S_HS}) ? tmp_r : rd_r;
    // Write side: next write location and data available to read
    uef_ring u_wr_ring (
        .size_i(size_r),
        .head_i(wr_head),
        .tail_i(rd_r),
        .head_next_o(wr_adv),
        .dist_o(avail)
    );
    // Read side: next read location
    uef_ring u_rd_ring (
        .size_i(size_r),
        .head_i(rd_head),
        .tail_i(wr_r),
        .head_next_o(rd_adv),
        .dist_o()
    );
    // Packet size in bytes counts as half as many memory words
    assign maxw = {7'h00, pol_r.maxpkt_bytes[MAXPKT_W-1:1]};
    // Any bus address or data phase holds off memory traffic
    assign aph = hsel_i & htrans_i[1] & hready_i;
    assign io_stall = aph | dph_r;
    assign out_ready_o = (state_r == S_OUT) && !io_stall;
    assign accept = out_valid_i && out_ready_o;
    // Bus slave never waits and always answers OKAY
    assign hreadyout_o = 1'b1;
    assign hresp_o = 1'b0;
    assign hrdata_o = hrdata_r;
    assign out_hs_o = hs_r;
    assign out_ack_o = ack_r;
    assign in_send_o = send_r;
    assign in_nak_o = nak_r;
    assign in_len_o = len_r;
    assign in_word_valid_o = wv_r;
    assign in_word_o = word_r;
    assign mem_o = mem_r;
    // Register file and bus phases
    always_comb begin
        dph_nxt = aph;
        dwr_nxt = aph & hwrite_i;
        dadr_nxt = aph ? haddr_i[7:0] : dadr_r;
        hrdata_nxt = hrdata_r;
        if (aph && !hwrite_i) begin
            hrdata_nxt = rd_val(haddr_i[7:0],
                                {avail, 5'h00, (state_r != S_IDLE), (wr_adv == rd_r),
                                 (wr_r == rd_r), 3'h0, nakc_r},
                                {14'h0000, pol_r.maxpkt_bytes, 2'h0, pol_r.dir_in,
                                 pol_r.nak_tally_enable, pol_r.short_packet_nak_limit},
                                base_r, size_r, rd_r, wr_r);
        end
        base_nxt = base_r;
        size_nxt = size_r;
        pol_nxt = pol_r;
        if (dph_r && dwr_r) begin
            if (hit(dadr_r, OFF_BASE)) base_nxt = hwdata_i[ADDR_W-1:0];
            if (hit(dadr_r, OFF_SIZE)) size_nxt = hwdata_i[PTR_W-1:0];
            if (hit(dadr_r, OFF_POLICY)) begin
                pol_nxt.short_packet_nak_limit = hwdata_i[POL_LIMIT_LSB +: 4];
                pol_nxt.nak_tally_enable = hwdata_i[POL_NAKEN_BIT];
                pol_nxt.dir_in = hwdata_i[POL_DIRIN_BIT];
                pol_nxt.maxpkt_bytes = hwdata_i[POL_MAXPKT_LSB +: MAXPKT_W];
            end
        end
    end
    // Packet engine; firmware writes pointers, the core's own commit wins
    always_comb begin
        state_nxt = state_r;
        wr_nxt = wr_r;
        rd_nxt = rd_r;
        if (dph_r && dwr_r && hit(dadr_r, OFF_RDOFF)) rd_nxt = hwdata_i[PTR_W-1:0];
        if (dph_r && dwr_r && hit(dadr_r, OFF_WROFF)) wr_nxt = hwdata_i[PTR_W-1:0];
        tmp_nxt = tmp_r;
        remain_nxt = remain_r;
        len_nxt = len_r;
        nakc_nxt = nakc_r;
        blocked_nxt = blocked_r;
        hs_nxt = 1'b0;
        ack_nxt = ack_r;
        send_nxt = 1'b0;
        nak_nxt = 1'b0;
        wv_nxt = 1'b0;
        word_nxt = word_r;
        mem_nxt = mem_r;
        mem_nxt.req = 1'b0;
        mem_nxt.we = 1'b0;
        case (state_r)
            S_IDLE: begin
                if (out_start_i && !pol_r.dir_in) begin
                    tmp_nxt = wr_r; // Snapshot for rewind
                    blocked_nxt = 1'b0;
                    state_nxt = S_OUT;
                end else if (in_token_i && pol_r.dir_in) begin
                    tmp_nxt = rd_r;
                    if (avail >= maxw) begin
                        len_nxt = maxw;
                        send_nxt = 1'b1;
                    end else if (pol_r.nak_tally_enable &&
                                 nakc_r > {1'b0, pol_r.short_packet_nak_limit}) begin
                        len_nxt = avail;
                        send_nxt = 1'b1;
                    end else begin
                        nak_nxt = 1'b1;
                        if (nakc_r != NAKC_MAX) nakc_nxt = nakc_r + 5'h01;
                    end
                    remain_nxt = len_nxt;
                    if (send_nxt) state_nxt = (len_nxt == PTR_RST) ? S_HS : S_FETCH;
                end
            end
            S_OUT: begin
                if (accept) begin
                    // Oversize data is kept while room lasts
                    if (!blocked_r && wr_adv != rd_r) begin
                        tmp_nxt = wr_adv;
                        mem_nxt.req = 1'b1;
                        mem_nxt.we = 1'b1;
                        mem_nxt.addr = base_r + {2'b00, wr_adv};
                        mem_nxt.wdata = out_word_i;
                    end else begin
                        blocked_nxt = 1'b1;
                    end
                end else if (out_end_i) begin
                    hs_nxt = 1'b1;
                    ack_nxt = !blocked_r;
                    if (!blocked_r) begin
                        wr_nxt = tmp_r;
                        nakc_nxt = '0;
                    end
                    // On NAK the committed offset is left as it was
                    state_nxt = S_IDLE;
                end
            end
            S_FETCH: begin
                if (!io_stall) begin
                    tmp_nxt = rd_adv;
                    mem_nxt.req = 1'b1;
                    mem_nxt.addr = base_r + {2'b00, rd_adv};
                    remain_nxt = remain_r - 16'h0001;
                    state_nxt = S_WAIT;
                end
            end
            S_WAIT: state_nxt = S_LATCH;
            S_LATCH: begin
                word_nxt = mem_rdata_i;
                wv_nxt = 1'b1;
                state_nxt = (remain_r == PTR_RST) ? S_HS : S_FETCH;
            end
            S_HS: begin
                // Read offset moves only once the host has accepted
                if (in_ack_i) begin
                    rd_nxt = tmp_r;
                    nakc_nxt = '0;
                    state_nxt = S_IDLE;
                end else if (in_abort_i) begin
                    state_nxt = S_IDLE;
                end
            end
            default: state_nxt = S_IDLE;
        endcase
    end
    // State registers
    always_ff @(posedge clock_i) begin
        if (rst_i) begin
            state_r <= S_IDLE;
            wr_r <= PTR_RST;
            rd_r <= PTR_RST;
            tmp_r <= PTR_RST;
            size_r <= SIZE_RST;
            base_r <= BASE_RST;
            pol_r <= '{MAXPKT_RST, 1'b0, 1'b0, 4'h0};
            remain_r <= PTR_RST;
            len_r <= PTR_RST;
            nakc_r <= '0;
            blocked_r <= 1'b0;
            hs_r <= 1'b0;
            ack_r <= 1'b0;
            send_r <= 1'b0;
            nak_r <= 1'b0;
            wv_r <= 1'b0;
            word_r <= 16'h0000;
            mem_r <= '0;
            dph_r <= 1'b0;
            dwr_r <= 1'b0;
            dadr_r <= 8'h00;
            hrdata_r <= 32'h00000000;
        end else begin
            state_r <= state_nxt;
            wr_r <= wr_nxt;
            rd_r <= rd_nxt;
            tmp_r <= tmp_nxt;
            size_r <= size_nxt;
            base_r <= base_nxt;
            pol_r <= pol_nxt;
            remain_r <= remain_nxt;
            len_r <= len_nxt;
            nakc_r <= nakc_nxt;
            blocked_r <= blocked_nxt;
            hs_r <= hs_nxt;
            ack_r <= ack_nxt;
            send_r <= send_nxt;
            nak_r <= nak_nxt;
            wv_r <= wv_nxt;
            word_r <= word_nxt;
            mem_r <= mem_nxt;
            dph_r <= dph_nxt;
            dwr_r <= dwr_nxt;
            dadr_r <= dadr_nxt;
            hrdata_r <= hrdata_nxt;
        end
    end
    // Checks on the pointer engine
    default clocking cb @(posedge clock_i); endclocking
    default disable iff (rst_i);
    ptr_reset_zero_a: assert property (@(posedge clock_i) disable iff (1'b0) rst_i |=>
        wr_r == 16'h0000 && rd_r == 16'h0000) else $error("pointers not zero after reset");
    ptr_wrap_a: assert property (accept && !blocked_r && wr_adv != rd_r &&
        tmp_r == size_r - 16'h0001 |=> tmp_r == 16'h0000) else $error("no wrap to zero");
    preinc_addr_a: assert property (mem_r.req |-> mem_r.addr == base_r + {2'b00, tmp_r})
        else $error("memory access not at pre-incremented pointer");
    io_stall_a: assert property (io_stall |=> !mem_r.req)
        else $error("memory access during register access");
    collide_block_a: assert property (accept && wr_adv == rd_r |=>
        blocked_r && !mem_r.req) else $error("write pointer advanced onto read pointer");
    out_ack_commit_a: assert property (out_hs_o && out_ack_o |-> wr_r == $past(tmp_r))
        else $error("acked packet did not commit write offset");
    out_nak_keep_a: assert property (state_r == S_OUT && blocked_r && out_end_i |=>
        out_hs_o && !out_ack_o && wr_r == $past(wr_r)) else $error("overflow not refused");
    in_nak_count_a: assert property (in_nak_o && $past(nakc_r) != 5'h1f |->
        nakc_r == $past(nakc_r) + 5'h01) else $error("nak count did not step");
    tally_off_a: assert property (in_send_o && !pol_r.nak_tally_enable |->
        in_len_o == maxw) else $error("short packet sent with tally disabled");
    in_ack_clear_a: assert property (state_r == S_HS && in_ack_i |=>
        nakc_r == 5'h00 && rd_r == $past(tmp_r) && state_r == S_IDLE) else $error("ack dropped");
    out_ack_c: cover property (out_hs_o && out_ack_o);
    out_nak_c: cover property (out_hs_o && !out_ack_o);
    in_short_c: cover property (in_send_o && in_len_o < maxw);
    in_full_c: cover property (in_send_o ##[1:200] in_ack_i);
endmodule : uef_core

// ### dv/uef_mem_model.sv
// Behavioural buffer memory that answers the pointer core's word requests
`timescale 1ns/10ps
module uef_mem_model (
    // Clock
    input wire logic clock_i,
    // Word request and read data
    input wire uef_pkg::uef_mem_req_t mem_i,
    output logic [uef_pkg::DATA_W-1:0] rdata_o
);
    import uef_pkg::*;
    logic [DATA_W-1:0] mem [0:1023];

    // Idle cycles toggle the read bus so a stale word is never mistaken for fresh data
    initial begin
        rdata_o = 16'ha5a5;
    end

    // Whole 16-bit words only, read data one cycle after the request
    always @(posedge clock_i) begin
        if (mem_i.req && mem_i.we) begin
            mem[mem_i.addr[9:0]] <= mem_i.wdata;
        end
        if (mem_i.req && !mem_i.we) begin
            rdata_o <= mem[mem_i.addr[9:0]];
        end else begin
            rdata_o <= ~rdata_o;
        end
    end
endmodule : uef_mem_model

// ### dv/usb_endpoint_circular_fifo_test.sv
// Self-checking bench for the endpoint circular FIFO pointer block
`timescale 1ns/10ps
module usb_endpoint_circular_fifo_test;
    import uef_pkg::*;
    typedef struct {
        logic [7:0] wa;
        logic [31:0] wd;
        logic [7:0] ra;
        logic [31:0] ex;
        logic [31:0] mk;
    } uef_row_t;
    logic clock_i = 1'b0;
    logic rst_i = 1'b1;
    logic hsel = 1'b0;
    logic hwrite = 1'b0;
    logic [1:0] htrans = 2'b00;
    logic [2:0] hsize = 3'b010;
    logic [31:0] haddr = 32'h0;
    logic [31:0] hwdata = 32'h0;
    logic [31:0] hrdata;
    logic [31:0] v;
    logic hready, hresp, ordy, ohs, oack, isend, inak, iwv;
    logic ostart = 1'b0;
    logic ovalid = 1'b0;
    logic oend = 1'b0;
    logic itok = 1'b0;
    logic iack = 1'b0;
    logic iabort = 1'b0;
    logic [15:0] oword = 16'h0;
    logic [15:0] ilen, iword, mrd;
    uef_mem_req_t mreq;
    int fail_count = 0;
    int comparisons = 0;
    // Register writes with read-back expectations, masked to the fields that matter
    uef_row_t rows [10] = '{
        '{OFF_BASE, 32'hffffffff, OFF_BASE, 32'h3ffff, 32'hffffffff},
        '{OFF_SIZE, 32'h000f0008, OFF_SIZE, 32'h8, 32'hffffffff},
        '{8'h18, 32'h5a5a5a5a, 8'h18, 32'h0, 32'hffffffff},
        '{OFF_RDOFF, 32'h3, OFF_STATUS, 32'h0, 32'h100},
        '{OFF_WROFF, 32'h2, OFF_STATUS, 32'h00070200, 32'hffff0300},
        '{OFF_WROFF, 32'h3, OFF_STATUS, 32'h00000100, 32'hffff0300},
        '{OFF_POLICY, 32'h0000fc3f, OFF_POLICY, 32'h0000fc3f, 32'h3ff3f},
        '{OFF_STATUS, 32'hffffffff, OFF_STATUS, 32'h00000100, 32'hffff0300},
        '{OFF_RDOFF, 32'h1, OFF_RDOFF, 32'h1, 32'hffff},
        '{OFF_WROFF, 32'h1, OFF_WROFF, 32'h1, 32'hffff}
    };

    // Design and the buffer memory behind it; one slave, so hreadyout is hready
    uef_core DUT (.clock_i(clock_i), .rst_i(rst_i), .hsel_i(hsel), .haddr_i(haddr),
        .htrans_i(htrans), .hwrite_i(hwrite), .hsize_i(hsize), .hwdata_i(hwdata),
        .hready_i(hready), .hreadyout_o(hready), .hresp_o(hresp), .hrdata_o(hrdata),
        .out_start_i(ostart), .out_valid_i(ovalid), .out_word_i(oword), .out_ready_o(ordy),
        .out_end_i(oend), .out_hs_o(ohs), .out_ack_o(oack), .in_token_i(itok),
        .in_send_o(isend), .in_nak_o(inak), .in_len_o(ilen), .in_word_valid_o(iwv),
        .in_word_o(iword), .in_ack_i(iack), .in_abort_i(iabort), .mem_o(mreq),
        .mem_rdata_i(mrd));
    uef_mem_model mdl (.clock_i(clock_i), .mem_i(mreq), .rdata_o(mrd));

    // 20 MHz clock
    initial begin
        forever #25 clock_i = ~clock_i;
    end

    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        comparisons++;
        if (got !== exp) begin
            fail_count++;
            $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask : chk

    function automatic logic sig(input int k);
        case (k)
            0: return hready;
            1: return ordy;
            2: return ohs;
            3: return isend | inak;
            default: return iwv;
        endcase
    endfunction : sig

    // Sampled at the falling edge, where nothing launched by the rising edge is still moving
    task automatic waitfor(input int k);
        int n;
        n = 0;
        do @(negedge clock_i);
        while (sig(k) !== 1'b1 && ++n < 64);
        if (n >= 64) begin
            fail_count++;
            $display("BAD t=%0t wait=%h exp=%h", $time, k, 1);
        end
    endtask : waitfor

    // Single AHB-Lite word transfer; hready is only judged at rising edges
    task automatic bus(input logic wr, input logic [7:0] a, input logic [31:0] wd,
                       output logic [31:0] rd);
        @(posedge clock_i);
        hsel <= 1'b1;
        htrans <= 2'b10;
        haddr <= {24'h000000, a};
        hwrite <= wr;
        do @(posedge clock_i);
        while (hready !== 1'b1);
        htrans <= 2'b00;
        hwdata <= wd;
        do @(posedge clock_i);
        while (hready !== 1'b1);
        rd = hrdata;
    endtask : bus

    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        logic [31:0] x;
        bus(1'b1, a, d, x);
    endtask : wr

    task automatic rdc(input logic [7:0] a, input logic [31:0] ex, input logic [31:0] mk);
        logic [31:0] x;
        bus(1'b0, a, 32'h0, x);
        chk(x & mk, ex);
        chk({31'h0, hresp}, 32'h0);
    endtask : rdc

    // One OUT packet of n words counting up from d, then the handshake
    task automatic out_pkt(input int n, input logic [15:0] d, input logic ack);
        @(posedge clock_i);
        ostart <= 1'b1;
        @(posedge clock_i);
        ostart <= 1'b0;
        for (int i = 0; i < n; i++) begin
            ovalid <= 1'b1;
            oword <= d + 16'(i);
            waitfor(1);
            @(posedge clock_i);
        end
        ovalid <= 1'b0;
        oend <= 1'b1;
        @(posedge clock_i);
        oend <= 1'b0;
        waitfor(2);
        chk({31'h0, oack}, {31'h0, ack});
    endtask : out_pkt

    // One IN token; words are expected from the location after rd, wrapping at size 8
    task automatic in_tok(input logic snd, input int len, input logic ack, input int rd);
        @(posedge clock_i);
        itok <= 1'b1;
        @(posedge clock_i);
        itok <= 1'b0;
        waitfor(3);
        chk({30'h0, isend, inak}, {30'h0, snd, !snd});
        if (snd) begin
            chk({16'h0, ilen}, 32'(len));
            for (int i = 1; i <= len; i++) begin
                waitfor(4);
                chk({16'h0, iword}, {16'h0, mdl.mem[10'h100 + 10'((rd + i) % 8)]});
            end
            @(posedge clock_i);
            iack <= ack;
            iabort <= !ack;
            @(posedge clock_i);
            iack <= 1'b0;
            iabort <= 1'b0;
        end
    endtask : in_tok

    task automatic done(input string s);
        $display("test %s finished", s);
    endtask : done

    task results;
        $display("comparisons=%0d fail_count=%0d", comparisons, fail_count);
        if (fail_count == 0 && comparisons > 0) begin
            $display("[ PASS ]");
        end else begin
            $display("[ FAIL ]");
        end
        $finish;
    endtask : results

    // No buffer word may be taken while a register access is in its address phase
    always @(negedge clock_i) begin
        if (hsel && htrans[1] && ordy === 1'b1) begin
            chk(32'h1, 32'h0);
        end
    end

    // Cut a hang short; the tests need a few hundred cycles
    initial begin
        repeat (20000) @(posedge clock_i);
        fail_count++;
        results();
    end

    // Main sequence
    initial begin
        repeat (10) @(posedge clock_i);
        rst_i <= 1'b0;
        foreach (rows[i]) begin
            wr(rows[i].wa, rows[i].wd);
            rdc(rows[i].ra, rows[i].ex, rows[i].mk);
        end
        done("table");
        @(posedge clock_i);
        rst_i <= 1'b1;
        repeat (2) @(posedge clock_i);
        rst_i <= 1'b0;
        rdc(OFF_RDOFF, 32'h0, 32'hffff);
        rdc(OFF_WROFF, 32'h0, 32'hffff);
        rdc(OFF_POLICY, {14'h0, MAXPKT_RST, 8'h00}, 32'h3ff3f);
        // Size is zero after reset, so the buffer has no room and shows full beside empty
        rdc(OFF_STATUS, 32'h300, 32'hffff071f);
        done("reset");
        // Buffer at 0x100, eight words, OUT with a two-word packet size
        wr(OFF_BASE, 32'h100);
        wr(OFF_SIZE, 32'h8);
        wr(OFF_POLICY, 32'h400);
        mdl.mem[10'h100] = 16'hbeef;
        out_pkt(3, 16'h1000, 1'b1);
        rdc(OFF_WROFF, 32'h3, 32'hffff);
        chk({16'h0, mdl.mem[10'h101]}, 32'h1000);
        chk({16'h0, mdl.mem[10'h103]}, 32'h1002);
        fork
            out_pkt(5, 16'h2000, 1'b0);
            begin
                repeat (3) @(posedge clock_i);
                bus(1'b0, OFF_STATUS, 32'h0, v);
            end
        join
        // The status read landed mid-packet, so the engine must show busy
        chk(v & 32'h400, 32'h400);
        rdc(OFF_WROFF, 32'h3, 32'hffff);
        chk({16'h0, mdl.mem[10'h107]}, 32'h2003);
        chk({16'h0, mdl.mem[10'h100]}, 32'hbeef);
        wr(OFF_RDOFF, 32'h3);
        out_pkt(6, 16'h3000, 1'b1);
        rdc(OFF_WROFF, 32'h1, 32'hffff);
        chk({16'h0, mdl.mem[10'h100]}, 32'h3004);
        out_pkt(2, 16'h4000, 1'b0);
        rdc(OFF_WROFF, 32'h1, 32'hffff);
        done("out");
        // IN with a four-word packet size, tally on with limit 1
        wr(OFF_POLICY, 32'h831);
        wr(OFF_RDOFF, 32'h0);
        wr(OFF_WROFF, 32'h2);
        in_tok(1'b0, 0, 1'b0, 0);
        in_tok(1'b0, 0, 1'b0, 0);
        rdc(OFF_STATUS, 32'h00020002, 32'hffff001f);
        in_tok(1'b1, 2, 1'b1, 0);
        rdc(OFF_RDOFF, 32'h2, 32'hffff);
        rdc(OFF_STATUS, 32'h100, 32'hffff011f);
        wr(OFF_POLICY, 32'h820);
        wr(OFF_WROFF, 32'h3);
        repeat (3) in_tok(1'b0, 0, 1'b0, 0);
        wr(OFF_WROFF, 32'h6);
        in_tok(1'b1, 4, 1'b0, 2);
        rdc(OFF_RDOFF, 32'h2, 32'hffff);
        in_tok(1'b1, 4, 1'b1, 2);
        wr(OFF_WROFF, 32'h2);
        in_tok(1'b1, 4, 1'b1, 6);
        rdc(OFF_RDOFF, 32'h2, 32'hffff);
        done("in");
        results();
    end
endmodule : usb_endpoint_circular_fifo_test
